// ==== src/softstart_pkg.sv ====
package softstart_pkg;
  // Clock and switching-cycle timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SW_PERIOD_NS = 2100;
  localparam int STROBES_PER_CYCLE = 6;
  localparam int SUB_CLKS = SW_PERIOD_NS / (STROBES_PER_CYCLE * CLK_PERIOD_NS);
  localparam logic [2:0] LAST_PHASE = 3'(STROBES_PER_CYCLE - 1);
  localparam logic [2:0] HALF_WAIT_STROBES = 3'(STROBES_PER_CYCLE / 2);

  // Soft-start counts in switching cycles
  localparam logic [15:0] SS_DELAY_CYC = 16'h0040;
  localparam logic [15:0] SS_FAST_CYC = 16'h0280;
  localparam logic [15:0] FAST_STEP_CYC = 16'h0020;
  localparam logic [15:0] SLOW_STEP_CYC = 16'h0010;
  localparam logic [15:0] OFS_STEP_CYC = 16'h0050;
  localparam logic [1:0] NOLOAD_CYC = 2'h2;

  // Codes in 12.5 mV units
  localparam logic [7:0] FAST_STEP_UNITS = 8'h02;
  localparam logic [3:0] OFS_START_UNITS = 4'h8;
  localparam logic [5:0] OFF_CODE_A = 6'h3F;
  localparam logic [5:0] OFF_CODE_B = 6'h3E;
  localparam logic [5:0] WRAP_CODE = 6'h14;
  localparam logic [7:0] LOW_BASE = 8'h57;
  localparam logic [7:0] HIGH_BASE = 8'h95;

  typedef enum logic [2:0] {
    ST_SHUT, ST_DELAY, ST_RAMP, ST_RUN, ST_NOLOAD, ST_FAULT
  } seq_state_t;
endpackage

// ==== src/vid_softstart_sequencer.sv ====
`timescale 1ns/1ps
module vid_softstart_sequencer #(
  parameter int SUB_CLKS = softstart_pkg::SUB_CLKS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Enable conditions and voltage code (asynchronous pins)
  input wire logic por_ok_in,
  input wire logic thresh_enable_in,
  input wire logic logic_level_enable_in,
  input wire logic [4:0] voltage_code,
  input wire logic half_step_bit,
  // Comparator results (asynchronous)
  input wire logic dac_ge_vout_in,
  input wire logic in_window_in,
  input wire logic ov_trip_in,
  // Outputs
  output logic pwm_oe,
  output logic output_ok_flag,
  output logic [7:0] dac_code,
  output logic [3:0] sense_offset,
  output logic ovp_shutdown_level,
  output logic ov_latched
);

  // Decode a six-bit voltage code into 12.5 mV units; the table wraps at 010100
  function automatic logic [7:0] code_units(input logic [5:0] c);
    if (c <= softstart_pkg::WRAP_CODE) begin
      code_units = softstart_pkg::LOW_BASE - {2'h0, c};
    end else begin
      code_units = softstart_pkg::HIGH_BASE - {2'h0, c};
    end
  endfunction

  function automatic logic is_off_code(input logic [5:0] c);
    is_off_code = (c == softstart_pkg::OFF_CODE_A) || (c == softstart_pkg::OFF_CODE_B);
  endfunction

  // Two-flop synchronisers for all pin-level inputs
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {ov_trip_in, in_window_in, dac_ge_vout_in, logic_level_enable_in,
                 thresh_enable_in, por_ok_in, voltage_code, half_step_bit};
      sync_b <= sync_a;
    end
  end

  logic [5:0] code_s;
  logic en_ok;
  logic dac_ge_vout;
  logic in_window;
  logic ov_trip;
  logic noload;
  logic [7:0] target;
  assign code_s = sync_b[5:0];
  assign en_ok = sync_b[6] && sync_b[7] && sync_b[8];
  assign dac_ge_vout = sync_b[9];
  assign in_window = sync_b[10];
  assign ov_trip = sync_b[NSYNC - 1];
  assign noload = is_off_code(code_s);
  assign target = code_units(code_s);

  // Six sampling strobes per switching cycle; the last one is the cycle tick
  logic [$clog2(SUB_CLKS + 1)-1:0] sub_cnt;
  logic [2:0] phase;
  logic strobe;
  logic tick;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sub_cnt <= '0;
      phase <= 3'h0;
      strobe <= 1'b0;
    end else begin
      strobe <= (sub_cnt == ($bits(sub_cnt))'(SUB_CLKS - 1));
      if (sub_cnt == ($bits(sub_cnt))'(SUB_CLKS - 1)) begin
        sub_cnt <= '0;
        phase <= (phase == softstart_pkg::LAST_PHASE) ? 3'h0 : phase + 3'h1;
      end else begin
        sub_cnt <= sub_cnt + 1'b1;
      end
    end
  end
  assign tick = strobe && (phase == 3'h0);

  // Sequencer state
  softstart_pkg::seq_state_t state;
  logic [15:0] cyc_cnt;
  logic [1:0] nl_cnt;
  logic go;
  assign go = en_ok && !noload && !ov_latched;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= softstart_pkg::ST_SHUT;
      cyc_cnt <= 16'h0000;
      nl_cnt <= 2'h0;
    end else if (!en_ok) begin
      state <= softstart_pkg::ST_SHUT;
    end else if (ov_latched && state != softstart_pkg::ST_SHUT) begin
      state <= softstart_pkg::ST_FAULT;
    end else begin
      unique case (state)
        softstart_pkg::ST_SHUT: begin
          cyc_cnt <= 16'h0000;
          if (go) begin
            state <= softstart_pkg::ST_DELAY;
          end
        end
        softstart_pkg::ST_DELAY, softstart_pkg::ST_RAMP, softstart_pkg::ST_RUN: begin
          if (noload) begin
            state <= softstart_pkg::ST_NOLOAD;
            nl_cnt <= 2'h0;
          end else if (tick) begin
            if (state == softstart_pkg::ST_DELAY &&
                cyc_cnt == softstart_pkg::SS_DELAY_CYC - 16'h0001) begin
              state <= softstart_pkg::ST_RAMP;
              cyc_cnt <= 16'h0000;
            end else if (state == softstart_pkg::ST_RAMP && dac_code == target) begin
              state <= softstart_pkg::ST_RUN;
            end else if (cyc_cnt != 16'hFFFF) begin
              cyc_cnt <= cyc_cnt + 16'h0001;
            end
          end
        end
        softstart_pkg::ST_NOLOAD: begin
          if (tick) begin
            nl_cnt <= nl_cnt + 2'h1;
            if (nl_cnt == softstart_pkg::NOLOAD_CYC - 2'h1) begin
              state <= softstart_pkg::ST_SHUT;
            end
          end
        end
        softstart_pkg::ST_FAULT: begin
          state <= softstart_pkg::ST_FAULT;
        end
        default: state <= softstart_pkg::ST_SHUT;
      endcase
    end
  end

  // Over-voltage latch: only an enable or bias drop clears it, never a code
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ov_latched <= 1'b0;
    end else if (ov_trip && en_ok) begin
      ov_latched <= 1'b1;
    end else if (!en_ok) begin
      ov_latched <= 1'b0;
    end
  end

  // Ramp step moments, counted in switching cycles
  logic in_fast;
  logic fast_step;
  logic slow_step;
  logic ofs_step;
  assign in_fast = cyc_cnt < softstart_pkg::SS_FAST_CYC;
  assign fast_step = in_fast &&
      (cyc_cnt % softstart_pkg::FAST_STEP_CYC == softstart_pkg::FAST_STEP_CYC - 16'h0001);
  assign slow_step = !in_fast &&
      (cyc_cnt % softstart_pkg::SLOW_STEP_CYC == softstart_pkg::SLOW_STEP_CYC - 16'h0001);
  assign ofs_step = in_fast &&
      (cyc_cnt % softstart_pkg::OFS_STEP_CYC == softstart_pkg::OFS_STEP_CYC - 16'h0001);

  // On-the-fly code tracking
  logic signed [8:0] diff;
  logic signed [8:0] pend_diff;
  logic pending;
  logic slewing;
  logic [2:0] wait_cnt;
  assign diff = $signed({1'b0, target}) - $signed({1'b0, dac_code});

  // DAC code: zero in shutdown, ramps in soft start, tracks the code when running
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dac_code <= 8'h00;
      pending <= 1'b0;
      pend_diff <= 9'sh000;
      wait_cnt <= 3'h0;
      slewing <= 1'b0;
    end else if (state == softstart_pkg::ST_SHUT || state == softstart_pkg::ST_DELAY) begin
      dac_code <= 8'h00;
      pending <= 1'b0;
      slewing <= 1'b0;
    end else if (state == softstart_pkg::ST_RAMP) begin
      if (tick && dac_code < target) begin
        if (fast_step) begin
          dac_code <= (target - dac_code >= softstart_pkg::FAST_STEP_UNITS) ?
              dac_code + softstart_pkg::FAST_STEP_UNITS : target;
        end else if (slow_step) begin
          dac_code <= dac_code + 8'h01;
        end
      end
    end else if (state == softstart_pkg::ST_RUN && strobe) begin
      if (diff == 9'sh000) begin
        pending <= 1'b0;
        slewing <= 1'b0;
      end else if (diff > 9'sh001 || diff < -9'sh001 || slewing) begin
        // A jump keeps stepping every strobe until equal, last unit included
        dac_code <= (diff > 9'sh000) ? dac_code + 8'h01 : dac_code - 8'h01;
        pending <= 1'b0;
        slewing <= 1'b1;
      end else if (!pending) begin
        pending <= 1'b1;
        pend_diff <= diff;
        wait_cnt <= 3'h1;
      end else if (diff != pend_diff) begin
        pending <= 1'b0;
      end else if (wait_cnt == softstart_pkg::HALF_WAIT_STROBES) begin
        dac_code <= (diff > 9'sh000) ? dac_code + 8'h01 : dac_code - 8'h01;
        pending <= 1'b0;
      end else begin
        wait_cnt <= wait_cnt + 3'h1;
      end
    end
  end

  // Remote-sense offset: full at enable, falls one unit every 80 ramp cycles
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sense_offset <= 4'h0;
    end else if (state == softstart_pkg::ST_SHUT) begin
      sense_offset <= 4'h0;
    end else if (state == softstart_pkg::ST_DELAY) begin
      sense_offset <= softstart_pkg::OFS_START_UNITS;
    end else if (state == softstart_pkg::ST_RAMP && tick && ofs_step && sense_offset != 4'h0) begin
      sense_offset <= sense_offset - 4'h1;
    end
  end

  // PWM release: held off until the ramping DAC catches the output
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwm_oe <= 1'b0;
    end else if (state == softstart_pkg::ST_SHUT || state == softstart_pkg::ST_DELAY ||
                 state == softstart_pkg::ST_FAULT) begin
      pwm_oe <= 1'b0;
    end else if (state == softstart_pkg::ST_RAMP && dac_ge_vout) begin
      pwm_oe <= 1'b1;
    end
  end

  // Status outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      output_ok_flag <= 1'b0;
      ovp_shutdown_level <= 1'b1;
    end else begin
      output_ok_flag <= (state == softstart_pkg::ST_RUN) && in_window;
      ovp_shutdown_level <= (state == softstart_pkg::ST_SHUT);
    end
  end

  // Checks
  sequence s_noload_entry;
    state == softstart_pkg::ST_RUN && noload && en_ok && !ov_latched;
  endsequence

  a_shut_pwm_off: assert property (@(posedge sys_clk) disable iff (rst)
    state == softstart_pkg::ST_SHUT |=> !pwm_oe)
    else $error("PWM released in shutdown");
  a_start_now: assert property (@(posedge sys_clk) disable iff (rst)
    state == softstart_pkg::ST_SHUT && go |=> state == softstart_pkg::ST_DELAY)
    else $error("Soft start not begun at once");
  a_enable_drop: assert property (@(posedge sys_clk) disable iff (rst)
    !en_ok |=> state == softstart_pkg::ST_SHUT)
    else $error("Disable not honoured");
  a_noload_wait: assert property (@(posedge sys_clk) disable iff (rst)
    s_noload_entry ##1 (state == softstart_pkg::ST_NOLOAD && en_ok)[*2]
    |-> !ovp_shutdown_level)
    else $error("Shutdown level before two cycles");
  a_delay_len: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(state == softstart_pkg::ST_RAMP) |-> $past(cyc_cnt) == 16'h003F)
    else $error("Delay not 64 cycles");
  a_ov_hold: assert property (@(posedge sys_clk) disable iff (rst)
    ov_latched && en_ok |=> ov_latched)
    else $error("Over-voltage latch cleared by code");
  a_dac_one_step: assert property (@(posedge sys_clk) disable iff (rst)
    state == softstart_pkg::ST_RUN && $past(state) == softstart_pkg::ST_RUN
    |-> dac_code - $past(dac_code) inside {8'h00, 8'h01, 8'hFF})
    else $error("DAC moved more than one unit");
  a_cancel_step: assert property (@(posedge sys_clk) disable iff (rst)
    state == softstart_pkg::ST_RUN && strobe && pending && diff != pend_diff &&
    diff inside {9'sh001, -9'sh001} |=> $stable(dac_code))
    else $error("Cancelled step executed");
  a_output_ok_flag_run: assert property (@(posedge sys_clk) disable iff (rst)
    output_ok_flag |-> $past(state) == softstart_pkg::ST_RUN)
    else $error("Power good outside run");

endmodule

// ==== dv/proc_drive_model.sv ====
`timescale 1ns/1ps
module proc_drive_model (
  // Clock and code request from the bench
  input wire logic sys_clk,
  input wire logic [5:0] req_code,
  // Device side
  input wire logic pwm_oe,
  input wire logic [7:0] dac_code,
  output logic [4:0] voltage_code,
  output logic half_step_bit,
  output logic dac_ge_vout_in,
  output logic in_window_in
);
  logic [5:0] code = 6'h14;
  logic [7:0] vout = 8'h14;
  assign {voltage_code, half_step_bit} = code;
  // Code pins move off the sampling edge; drivers are up from time zero
  always @(negedge sys_clk) begin
    code <= req_code; // Bench asks single steps except in the jump
    if (pwm_oe) begin
      vout <= dac_code;
    end
  end
  // Output holds its pre-bias until driven, so the DAC must climb to it
  assign dac_ge_vout_in = dac_code >= vout;
  assign in_window_in = pwm_oe && dac_code == vout;
endmodule

// ==== dv/test_vid_softstart_sequencer.sv ====
`timescale 1ns/1ps
module test_vid_softstart_sequencer;
  localparam int SUBC = 2;
  localparam int CYC = 6 * SUBC;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b0;
  logic th = 1'b0;
  logic en = 1'b0;
  logic ovt = 1'b0;
  logic [5:0] req = 6'h14;
  logic pwm_oe, ok, ovp_lvl, ov_lat, half, ge, win;
  logic [4:0] code;
  logic [7:0] dac_code;
  logic [3:0] ofs;
  int fail_count = 0;
  int samples_checked = 0;
  int n;
  vid_softstart_sequencer #(.SUB_CLKS(SUBC)) uut (.sys_clk(sys_clk), .rst(rst),
    .por_ok_in(por), .thresh_enable_in(th), .logic_level_enable_in(en),
    .voltage_code(code), .half_step_bit(half), .dac_ge_vout_in(ge), .in_window_in(win),
    .ov_trip_in(ovt), .pwm_oe(pwm_oe), .output_ok_flag(ok), .dac_code(dac_code),
    .sense_offset(ofs), .ovp_shutdown_level(ovp_lvl), .ov_latched(ov_lat));
  proc_drive_model partner (.sys_clk(sys_clk), .req_code(req), .pwm_oe(pwm_oe),
    .dac_code(dac_code), .voltage_code(code), .half_step_bit(half),
    .dac_ge_vout_in(ge), .in_window_in(win));
  // 20 MHz clock
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic check_range(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h..%0h", $time, got, lo, hi);
    end
  endtask
  task automatic cycles(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  // Bounded wait for a DAC level; a miss shows up in the count check
  task automatic wait_dac(input logic [7:0] exp, input int lim, output int cnt);
    cnt = 0;
    while (dac_code !== exp && cnt < lim) begin
      @(negedge sys_clk);
      cnt++;
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic t_gate();
    for (int i = 0; i < 3; i++) begin
      {por, th, en} = 3'b111 ^ (3'b001 << i);
      cycles(40);
      check({4'h0, ofs}, 8'h00); // Held in shutdown
      check({7'h0, pwm_oe}, 8'h00); // Outputs float
    end
    // Off code settles before all enables rise, so only the code can block
    req = 6'h3F;
    cycles(2);
    {por, th, en} = 3'b111;
    cycles(40);
    check({4'h0, ofs}, 8'h00); // First off code blocks start
    req = 6'h3E;
    cycles(40);
    check({4'h0, ofs}, 8'h00); // Second off code blocks start
    $display("gate test done");
  endtask
  task automatic t_softstart();
    req = 6'h14;
    cycles(5);
    check({4'h0, ofs}, 8'h08); // Offset at start, no extra delay
    wait_dac(8'h02, 2000, n);
    check_range(n, 96 * CYC - 20, 96 * CYC + 4); // Delay then double step
    check({7'h0, pwm_oe}, 8'h00); // DAC below output
    wait_dac(8'h28, 9000, n);
    check_range(n, 608 * CYC - 2, 608 * CYC + 2); // Fast phase span
    check({4'h0, ofs}, 8'h00); // Offset gone after fast phase
    wait_dac(8'h29, 400, n);
    check_range(n, 16 * CYC, 16 * CYC); // Single steps
    wait_dac(8'h43, 6000, n);
    check_range(n, 416 * CYC, 416 * CYC); // Ramp ends on target
    // Run is entered on the next cycle tick, power good one edge later
    cycles(2 * CYC);
    check({6'h0, pwm_oe, ok}, 8'h03); // Driven and in window
    $display("softstart test done");
  endtask
  task automatic t_dynamic();
    req = 6'h13;
    cycles(4);
    check(dac_code, 8'h43); // Still in half-cycle wait
    wait_dac(8'h44, 40, n);
    check_range(n, 2, 16); // One unit after the wait
    req = 6'h14;
    cycles(3);
    req = 6'h13;
    cycles(40);
    check(dac_code, 8'h44); // Pending step dropped
    // Difference flips from +1 to -1 inside the wait: the up step must never happen
    req = 6'h12;
    cycles(3);
    req = 6'h14;
    wait_dac(8'h45, 16, n);
    check_range(n, 16, 16); // Reversed difference cancels the step
    check(dac_code, 8'h43); // New difference stepped after its own wait
    req = 6'h0F;
    wait_dac(8'h48, 60, n);
    check_range(n, 9, 15); // Steps on every strobe until equal
    $display("dynamic test done");
  endtask
  task automatic t_noload();
    req = 6'h3F;
    cycles(6);
    check({7'h0, pwm_oe}, 8'h01); // Two-cycle grace
    wait_dac(8'h00, 60, n);
    check_range(n, 8, 40); // Shut after the grace
    check({6'h0, pwm_oe, ovp_lvl}, 8'h01); // Floating, trip level shut
    req = 6'h14;
    cycles(6);
    check({4'h0, ofs}, 8'h08); // Valid code restarts
    $display("noload test done");
  endtask
  task automatic t_ov();
    ovt = 1'b1;
    cycles(6);
    check({6'h0, ov_lat, pwm_oe}, 8'h02); // Trip latches
    ovt = 1'b0;
    req = 6'h3F;
    cycles(40);
    req = 6'h14;
    cycles(40);
    check({6'h0, ov_lat, pwm_oe}, 8'h02); // Code cycling keeps latch
    en = 1'b0;
    cycles(6);
    check({7'h0, ov_lat}, 8'h00); // Disable clears latch
    en = 1'b1;
    cycles(6);
    check({4'h0, ofs}, 8'h08); // Fresh start
    $display("overvoltage test done");
  endtask
  initial begin
    cycles(16);
    rst = 1'b0;
    cycles(2);
    check({4'h0, pwm_oe, ok, ovp_lvl, ov_lat}, 8'h02); // Reset levels
    check(dac_code | {4'h0, ofs}, 8'h00); // Reset levels
    t_gate();
    t_softstart();
    t_dynamic();
    t_noload();
    t_ov();
    summarize();
  end
  // Watchdog well past the expected run of about 14000 cycles
  initial begin
    cycles(40000);
    fail_count++;
    summarize();
  end
endmodule
